// >>> hdl/lane_ctrl_map.svh
// Timing counts and reset values for the lane passage-mode control
`ifndef LANE_CTRL_MAP_SVH
`define LANE_CTRL_MAP_SVH
`define CLK_HZ 20000000
`define ACCESS_TIME_S 6
`define ACCESS_CYCLES (`ACCESS_TIME_S * `CLK_HZ)
`define POWERUP_TIME_S 60
// Power-up plus the homing timeout stays a second inside the minute
`define POWERUP_CYCLES ((`POWERUP_TIME_S - 1) * `CLK_HZ - `HOME_CYCLES)
`define DEBOUNCE_TIME_MS 10
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_MS * (`CLK_HZ / 1000))
`define HOME_TIME_MS 500
`define HOME_CYCLES (`HOME_TIME_MS * (`CLK_HZ / 1000))
`define TIMER_W 32
`endif

// >>> hdl/lane_ctrl_pkg.sv
// Types for the lane passage-mode control
package lane_ctrl_pkg;
  typedef enum logic [1:0] {
    PASS_CONTROLLED = 2'h0,
    PASS_FREE = 2'h1,
    PASS_NONE = 2'h2
  } passage_mode_t;
  typedef enum logic [1:0] {
    OP_NORMALLY_CLOSED = 2'h0,
    OP_NORMALLY_OPEN = 2'h1,
    OP_BARRIER_OFF = 2'h2
  } operating_mode_t;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_HOMING = 3'h1,
    ST_IDLE = 3'h2,
    ST_OPEN_ENTRY = 3'h3,
    ST_OPEN_EXIT = 3'h4,
    ST_OVERRIDE = 3'h5
  } lane_state_t;
  typedef struct packed {
    logic free_sel;
    logic none_sel;
    logic auth;
    logic presence;
    logic passed;
  } dir_inputs_t;
  typedef struct packed {
    logic open;
    logic toward_exit;
    logic secure_hold;
  } arm_cmd_t;
endpackage

// >>> hdl/contact_debounce.sv
// Two-flop synchroniser and debounce filter for grounded contacts
`timescale 1ns/1ps
`include "lane_ctrl_map.svh"
module contact_debounce #(
  parameter int WIDTH = 1,
  parameter int COUNT = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] contact_n_i,
  output logic [WIDTH-1:0] active_o
);
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_a <= '1;
      sync_b <= '1;
    end else begin
      sync_a <= contact_n_i;
      sync_b <= sync_a;
    end
  end
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_bit
      logic [`TIMER_W-1:0] cnt;
      logic stable;
      assign active_o[g] = stable;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          cnt <= '0;
          stable <= 1'b0;
        end else if ((!sync_b[g]) == stable) begin
          cnt <= '0;
        end else if (cnt >= `TIMER_W'(COUNT - 1)) begin
          cnt <= '0;
          stable <= !sync_b[g];
        end else begin
          cnt <= cnt + `TIMER_W'(1);
        end
      end
    end
  endgenerate
endmodule

// >>> hdl/lane_mode_ctrl.sv
// Passage-mode and operating-mode control for one turnstile lane
`timescale 1ns/1ps
`include "lane_ctrl_map.svh"
// Operation
// - Controlled: closed, authorization opens one passage
// - Close on passage or six-second access timeout
// - Controlled passage is default mode
// - Free: no authorization, open on user entry
// - Free: close on passage or six-second delay
// - No passage: closed, authorization ignored
// - Life safety opens arms even in no passage
// - Normally closed: arms up, return after passage
// - Normally open: arms down, raise on violation
// - Barrier off: arms always down
// - Power-up completes within one minute
// - After power-up home arms, controlled both ways
// - Override opens arms, lane inactive until removed
// - Normally-open select input gives normally open
module lane_mode_ctrl #(
  parameter int unsigned ACCESS_CYCLES = `ACCESS_CYCLES,
  parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int unsigned HOME_CYCLES = `HOME_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic entry_free_passage_select_n_i,
  input wire logic exit_free_passage_select_n_i,
  input wire logic entry_no_passage_select_n_i,
  input wire logic exit_no_passage_select_n_i,
  input wire logic entry_authorization_in_n_i,
  input wire logic exit_authorization_in_n_i,
  input wire logic life_safety_override_in_n_i,
  input wire logic normally_open_select_n_i,
  input wire logic barrier_off_select_n_i,
  input wire logic entry_presence_i,
  input wire logic exit_presence_i,
  input wire logic passage_done_i,
  input wire logic home_reached_i,
  output logic arms_open_o,
  output logic arms_toward_exit_o,
  output logic arms_homing_o,
  output logic lane_ready_o,
  output logic lane_inactive_o,
  output logic violation_o,
  output lane_ctrl_pkg::passage_mode_t entry_mode_o,
  output lane_ctrl_pkg::passage_mode_t exit_mode_o,
  output lane_ctrl_pkg::operating_mode_t op_mode_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [12:0] raw_n;
  logic [12:0] act;
  lane_ctrl_pkg::dir_inputs_t ent;
  lane_ctrl_pkg::dir_inputs_t ext;
  logic override;
  logic norm_open_sel;
  logic barrier_off_sel;
  logic home_reached;

  // Sensor levels inverted so every bit idles high like a contact
  assign raw_n = {exit_free_passage_select_n_i, !home_reached_i, !passage_done_i,
                  !exit_presence_i, !entry_presence_i,
                  barrier_off_select_n_i, normally_open_select_n_i,
                  life_safety_override_in_n_i,
                  exit_authorization_in_n_i, entry_authorization_in_n_i,
                  exit_no_passage_select_n_i, entry_no_passage_select_n_i,
                  entry_free_passage_select_n_i};

  contact_debounce #(
    .WIDTH(13),
    .COUNT(DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .contact_n_i(raw_n),
    .active_o(act)
  );

  assign ent.free_sel = act[0];
  assign ext.free_sel = act[12];
  assign ent.none_sel = act[1];
  assign ext.none_sel = act[2];
  assign ent.auth = act[3];
  assign ext.auth = act[4];
  assign override = act[5];
  assign norm_open_sel = act[6];
  assign barrier_off_sel = act[7];
  assign ent.presence = act[8];
  assign ext.presence = act[9];
  assign ent.passed = act[10];
  assign ext.passed = act[10];
  assign home_reached = act[11];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode, no-passage wins over free when both are strapped
  function automatic lane_ctrl_pkg::passage_mode_t decode_mode(
      input lane_ctrl_pkg::dir_inputs_t d);
    if (d.none_sel) begin
      decode_mode = lane_ctrl_pkg::PASS_NONE;
    end else if (d.free_sel) begin
      decode_mode = lane_ctrl_pkg::PASS_FREE;
    end else begin
      decode_mode = lane_ctrl_pkg::PASS_CONTROLLED;
    end
  endfunction

  lane_ctrl_pkg::lane_state_t state;
  lane_ctrl_pkg::lane_state_t next_state;
  logic [`TIMER_W-1:0] timer;
  logic timer_done;
  logic [1:0] auth_prev;
  logic entry_go;
  logic exit_go;
  logic entry_violation;
  logic exit_violation;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      entry_mode_o <= lane_ctrl_pkg::PASS_CONTROLLED;
      exit_mode_o <= lane_ctrl_pkg::PASS_CONTROLLED;
      op_mode_o <= lane_ctrl_pkg::OP_NORMALLY_CLOSED;
    end else if (state == lane_ctrl_pkg::ST_POWERUP ||
                 state == lane_ctrl_pkg::ST_HOMING) begin
      entry_mode_o <= lane_ctrl_pkg::PASS_CONTROLLED;
      exit_mode_o <= lane_ctrl_pkg::PASS_CONTROLLED;
      op_mode_o <= lane_ctrl_pkg::OP_NORMALLY_CLOSED;
    end else begin
      entry_mode_o <= decode_mode(ent);
      exit_mode_o <= decode_mode(ext);
      if (barrier_off_sel) begin
        op_mode_o <= lane_ctrl_pkg::OP_BARRIER_OFF;
      end else if (norm_open_sel) begin
        op_mode_o <= lane_ctrl_pkg::OP_NORMALLY_OPEN;
      end else begin
        op_mode_o <= lane_ctrl_pkg::OP_NORMALLY_CLOSED;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      auth_prev <= 2'h0;
    end else begin
      auth_prev <= {ext.auth, ent.auth};
    end
  end

  always_comb begin
    entry_go = 1'b0;
    exit_go = 1'b0;
    entry_violation = 1'b0;
    exit_violation = 1'b0;
    case (entry_mode_o)
      lane_ctrl_pkg::PASS_CONTROLLED: begin
        entry_go = ent.auth && !auth_prev[0];
        entry_violation = ent.presence;
      end
      lane_ctrl_pkg::PASS_FREE: entry_go = ent.presence;
      default: entry_violation = ent.presence;
    endcase
    case (exit_mode_o)
      lane_ctrl_pkg::PASS_CONTROLLED: begin
        exit_go = ext.auth && !auth_prev[1];
        exit_violation = ext.presence;
      end
      lane_ctrl_pkg::PASS_FREE: exit_go = ext.presence;
      default: exit_violation = ext.presence;
    endcase
  end

  assign timer_done = (timer == '0);

  always_comb begin
    next_state = state;
    case (state)
      lane_ctrl_pkg::ST_POWERUP: begin
        if (timer_done) begin
          next_state = lane_ctrl_pkg::ST_HOMING;
        end
      end
      lane_ctrl_pkg::ST_HOMING: begin
        if (home_reached || timer_done) begin
          next_state = lane_ctrl_pkg::ST_IDLE;
        end
      end
      lane_ctrl_pkg::ST_IDLE: begin
        if (override) begin
          next_state = lane_ctrl_pkg::ST_OVERRIDE;
        end else if (entry_go) begin
          next_state = lane_ctrl_pkg::ST_OPEN_ENTRY;
        end else if (exit_go) begin
          next_state = lane_ctrl_pkg::ST_OPEN_EXIT;
        end
      end
      lane_ctrl_pkg::ST_OPEN_ENTRY, lane_ctrl_pkg::ST_OPEN_EXIT: begin
        if (override) begin
          next_state = lane_ctrl_pkg::ST_OVERRIDE;
        end else if (ent.passed || timer_done) begin
          next_state = lane_ctrl_pkg::ST_IDLE;
        end
      end
      lane_ctrl_pkg::ST_OVERRIDE: begin
        if (!override) begin
          next_state = lane_ctrl_pkg::ST_IDLE;
        end
      end
      default: next_state = lane_ctrl_pkg::ST_POWERUP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= lane_ctrl_pkg::ST_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer <= `TIMER_W'(POWERUP_CYCLES);
    end else if (next_state != state) begin
      case (next_state)
        lane_ctrl_pkg::ST_HOMING: timer <= `TIMER_W'(HOME_CYCLES);
        lane_ctrl_pkg::ST_OPEN_ENTRY, lane_ctrl_pkg::ST_OPEN_EXIT:
          timer <= `TIMER_W'(ACCESS_CYCLES - 1);
        default: timer <= '0;
      endcase
    end else if (!timer_done) begin
      timer <= timer - `TIMER_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arm drive: normally closed holds arms up unless a passage is open or the override is active
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arms_open_o <= 1'b0;
      arms_toward_exit_o <= 1'b0;
      arms_homing_o <= 1'b0;
      lane_ready_o <= 1'b0;
      lane_inactive_o <= 1'b1;
      violation_o <= 1'b0;
    end else begin
      arms_homing_o <= (state == lane_ctrl_pkg::ST_HOMING);
      lane_ready_o <= (state != lane_ctrl_pkg::ST_POWERUP &&
                       state != lane_ctrl_pkg::ST_HOMING);
      lane_inactive_o <= (state == lane_ctrl_pkg::ST_OVERRIDE ||
                          state == lane_ctrl_pkg::ST_POWERUP ||
                          state == lane_ctrl_pkg::ST_HOMING);
      violation_o <= (state == lane_ctrl_pkg::ST_IDLE) &&
                     (entry_violation || exit_violation);
      arms_toward_exit_o <= (state == lane_ctrl_pkg::ST_OPEN_ENTRY) ||
                            (state == lane_ctrl_pkg::ST_OVERRIDE);
      case (state)
        lane_ctrl_pkg::ST_OVERRIDE: arms_open_o <= 1'b1;
        lane_ctrl_pkg::ST_OPEN_ENTRY, lane_ctrl_pkg::ST_OPEN_EXIT:
          arms_open_o <= 1'b1;
        lane_ctrl_pkg::ST_IDLE: begin
          if (op_mode_o == lane_ctrl_pkg::OP_BARRIER_OFF) begin
            arms_open_o <= 1'b1;
          end else if (op_mode_o == lane_ctrl_pkg::OP_NORMALLY_OPEN) begin
            arms_open_o <= !(entry_violation || exit_violation);
          end else begin
            arms_open_o <= 1'b0;
          end
        end
        default: arms_open_o <= 1'b0;
      endcase
    end
  end
endmodule

// >>> verification/turnstile_properties.sv
// Checker for the lane passage-mode control
`timescale 1ns/1ps
module lane_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic life_safety_override_in_n_i,
  input wire logic passage_done_i,
  input wire logic arms_open_o,
  input wire logic arms_toward_exit_o,
  input wire logic lane_ready_o,
  input wire logic lane_inactive_o,
  input wire lane_ctrl_pkg::passage_mode_t entry_mode_o,
  input wire lane_ctrl_pkg::passage_mode_t exit_mode_o,
  input wire lane_ctrl_pkg::operating_mode_t op_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_not_early: assert property ($rose(rst_n_i) |-> (!lane_ready_o)[*8])
    else $error("lane ready too soon after reset");
  a_ready_in_time: assert property ($rose(rst_n_i) |-> ##[10:40] lane_ready_o)
    else $error("lane never became ready");
  a_ready_home_modes: assert property ($rose(lane_ready_o) |-> !arms_open_o
    && entry_mode_o == lane_ctrl_pkg::PASS_CONTROLLED
    && exit_mode_o == lane_ctrl_pkg::PASS_CONTROLLED)
    else $error("lane ready without home and controlled modes");
  a_override_opens: assert property ($fell(life_safety_override_in_n_i)
    ##1 (!life_safety_override_in_n_i)[*8]
    |-> ##[0:4] (arms_open_o && lane_inactive_o && arms_toward_exit_o))
    else $error("override did not open the arms");
  a_override_holds: assert property (!life_safety_override_in_n_i
    && lane_inactive_o && arms_open_o |=> arms_open_o)
    else $error("arms closed while override held");
  a_passage_closes: assert property ($rose(arms_open_o)
    && life_safety_override_in_n_i && op_mode_o == lane_ctrl_pkg::OP_NORMALLY_CLOSED
    |-> ##[1:30] !arms_open_o)
    else $error("arms not closed after access time");
  a_open_min_time: assert property (($rose(arms_open_o) && life_safety_override_in_n_i
    && op_mode_o == lane_ctrl_pkg::OP_NORMALLY_CLOSED
    && !passage_done_i) ##1 (!passage_done_i)[*6] |-> arms_open_o)
    else $error("arms closed early without passage");
  a_barrier_off_down: assert property ((op_mode_o == lane_ctrl_pkg::OP_BARRIER_OFF)[*4]
    |-> arms_open_o)
    else $error("arms raised while barrier off");
endmodule

bind lane_mode_ctrl lane_checker u_chk (.clk_i, .rst_n_i, .life_safety_override_in_n_i,
  .passage_done_i, .arms_open_o, .arms_toward_exit_o, .lane_ready_o, .lane_inactive_o,
  .entry_mode_o, .exit_mode_o, .op_mode_o);

// >>> verification/access_partner.sv
// Access control system model closing grounded authorization contacts
`timescale 1ns/1ps
module access_partner (
  input wire logic clk_i,
  input wire logic grant_i,
  input wire logic to_exit_i,
  input wire logic [3:0] lag_i,
  output logic entry_auth_n_o,
  output logic exit_auth_n_o
);
  logic [4:0] cnt = 5'h00;
  logic dir = 1'b0;
  logic shut;
  assign shut = (cnt != 5'h00) && (cnt < 5'h09);
  initial begin
    entry_auth_n_o = 1'b1;
    exit_auth_n_o = 1'b1;
  end
  // Lag first, then contact closed for eight cycles
  always @(posedge clk_i) begin
    if (grant_i && cnt == 5'h00) begin
      cnt <= {1'b0, lag_i} + 5'h08;
      dir <= to_exit_i;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
  // Open contact reads high through the pull-up
  always @(negedge clk_i) begin
    entry_auth_n_o <= !(shut && !dir);
    exit_auth_n_o <= !(shut && dir);
  end
endmodule

// >>> verification/test_turnstile_passage_mode_control.sv
// Self-checking bench for the lane passage-mode control
`timescale 1ns/1ps
module test_turnstile_passage_mode_control;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic entry_free_passage_select_n_i = 1'b1, exit_free_passage_select_n_i = 1'b1;
  logic entry_no_passage_select_n_i = 1'b1, exit_no_passage_select_n_i = 1'b1;
  logic life_safety_override_in_n_i = 1'b1, normally_open_select_n_i = 1'b1;
  logic barrier_off_select_n_i = 1'b1, entry_presence_i = 1'b0, exit_presence_i = 1'b0;
  logic passage_done_i = 1'b0, home_reached_i = 1'b0;
  logic entry_authorization_in_n_i, exit_authorization_in_n_i;
  logic arms_open_o, arms_toward_exit_o, arms_homing_o, lane_ready_o;
  logic lane_inactive_o, violation_o;
  lane_ctrl_pkg::passage_mode_t entry_mode_o, exit_mode_o;
  lane_ctrl_pkg::operating_mode_t op_mode_o;
  logic grant = 1'b0, to_exit = 1'b0;
  logic [3:0] lag = 4'h0;
  int bad_count = 0, compares = 0;

  always #25 clk_i = ~clk_i;
  lane_mode_ctrl #(.ACCESS_CYCLES(20), .POWERUP_CYCLES(10), .DEBOUNCE_CYCLES(2),
    .HOME_CYCLES(10)) DUT (.clk_i, .rst_n_i, .entry_free_passage_select_n_i,
    .exit_free_passage_select_n_i, .entry_no_passage_select_n_i, .exit_no_passage_select_n_i,
    .entry_authorization_in_n_i, .exit_authorization_in_n_i, .life_safety_override_in_n_i,
    .normally_open_select_n_i, .barrier_off_select_n_i, .entry_presence_i, .exit_presence_i,
    .passage_done_i, .home_reached_i, .arms_open_o, .arms_toward_exit_o, .arms_homing_o,
    .lane_ready_o, .lane_inactive_o, .violation_o, .entry_mode_o, .exit_mode_o, .op_mode_o);
  access_partner u_acs (.clk_i, .grant_i(grant), .to_exit_i(to_exit), .lag_i(lag),
    .entry_auth_n_o(entry_authorization_in_n_i), .exit_auth_n_o(exit_authorization_in_n_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_arms(input logic v, input int n);
    int i;
    for (i = 0; i < n && arms_open_o !== v; i++) begin
      step(1);
    end
    chk(8'(arms_open_o), 8'(v));
    if (arms_open_o !== v) close_out();
  endtask
  task automatic auth(input logic ex, input logic [3:0] lg);
    to_exit = ex;
    lag = lg;
    grant = 1'b1;
    step(1);
    grant = 1'b0;
  endtask
  task automatic walk();
    passage_done_i = 1'b1;
    step(6);
    passage_done_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_powerup();
    int i;
    step(15);
    chk(8'(arms_homing_o), 8'h01);
    home_reached_i = 1'b1;
    for (i = 0; i < 40 && lane_ready_o !== 1'b1; i++) begin
      step(1);
    end
    chk(8'(lane_ready_o), 8'h01);
    if (lane_ready_o !== 1'b1) close_out();
    chk(8'(arms_homing_o), 8'h00);
    chk(8'(entry_mode_o), 8'(lane_ctrl_pkg::PASS_CONTROLLED));
    chk(8'(exit_mode_o), 8'(lane_ctrl_pkg::PASS_CONTROLLED));
    chk(8'(op_mode_o), 8'(lane_ctrl_pkg::OP_NORMALLY_CLOSED));
    chk(8'(arms_open_o), 8'h00);
    home_reached_i = 1'b0;
  endtask
  task automatic s_controlled();
    auth(1'b0, 4'h0);
    wait_arms(1'b1, 20);
    chk(8'(arms_toward_exit_o), 8'h01);
    walk();
    wait_arms(1'b0, 12);
    auth(1'b1, 4'h9);
    wait_arms(1'b1, 30);
    chk(8'(arms_toward_exit_o), 8'h00);
    step(10);
    chk(8'(arms_open_o), 8'h01);
    wait_arms(1'b0, 20);
    step(4);
  endtask
  task automatic s_no_passage();
    entry_no_passage_select_n_i = 1'b0;
    step(8);
    chk(8'(entry_mode_o), 8'(lane_ctrl_pkg::PASS_NONE));
    chk(8'(exit_mode_o), 8'(lane_ctrl_pkg::PASS_CONTROLLED));
    auth(1'b0, 4'h0);
    repeat (25) begin
      step(1);
      chk(8'(arms_open_o), 8'h00);
    end
    life_safety_override_in_n_i = 1'b0;
    wait_arms(1'b1, 15);
    chk(8'(lane_inactive_o), 8'h01);
    step(20);
    chk(8'(arms_open_o), 8'h01);
    life_safety_override_in_n_i = 1'b1;
    wait_arms(1'b0, 15);
    exit_no_passage_select_n_i = 1'b0;
    step(8);
    chk(8'(exit_mode_o), 8'(lane_ctrl_pkg::PASS_NONE));
    entry_no_passage_select_n_i = 1'b1;
    exit_no_passage_select_n_i = 1'b1;
    step(8);
  endtask
  task automatic s_free();
    entry_free_passage_select_n_i = 1'b0;
    exit_free_passage_select_n_i = 1'b0;
    step(8);
    chk(8'(entry_mode_o), 8'(lane_ctrl_pkg::PASS_FREE));
    chk(8'(exit_mode_o), 8'(lane_ctrl_pkg::PASS_FREE));
    entry_presence_i = 1'b1;
    wait_arms(1'b1, 15);
    entry_presence_i = 1'b0;
    walk();
    wait_arms(1'b0, 12);
    entry_free_passage_select_n_i = 1'b1;
    exit_free_passage_select_n_i = 1'b1;
    step(8);
  endtask
  task automatic s_op_modes();
    normally_open_select_n_i = 1'b0;
    step(8);
    chk(8'(op_mode_o), 8'(lane_ctrl_pkg::OP_NORMALLY_OPEN));
    wait_arms(1'b1, 10);
    exit_presence_i = 1'b1;
    wait_arms(1'b0, 12);
    chk(8'(violation_o), 8'h01);
    exit_presence_i = 1'b0;
    wait_arms(1'b1, 15);
    normally_open_select_n_i = 1'b1;
    barrier_off_select_n_i = 1'b0;
    step(20);
    chk(8'(op_mode_o), 8'(lane_ctrl_pkg::OP_BARRIER_OFF));
    chk(8'(arms_open_o), 8'h01);
    barrier_off_select_n_i = 1'b1;
    wait_arms(1'b0, 15);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    rst_n_i = 1'b1;
    s_powerup();
    s_controlled();
    s_no_passage();
    s_free();
    s_op_modes();
    close_out();
  end
endmodule
